// >>> dv/scc_clock_ctrl_tb.sv
// Self-checking bench for the slow clock source control
`timescale 1ns/10ps
`include "scc_consts.svh"

module scc_clock_ctrl_tb;
    localparam int          WARM   = 16;
    localparam logic [11:0] A_EXT_IRQ_FLAG_CLOCK_SOURCE = {`SCC_IDX_EXT_IRQ_FLAG_CLOCK_SOURCE, 2'h0};
    localparam logic [11:0] A_PMR  = {`SCC_IDX_PMR, 2'h0};
    localparam logic [11:0] A_STS  = {`SCC_IDX_STATUS, 2'h0};
    localparam logic [11:0] A_NONE = 12'h100;

    logic                 ref_clk, reset, hsel, hwrite, hreadyout, hresp, rdy_q, rsp_q;
    logic [11:0]          haddr;
    logic [1:0]           htrans, div_code;
    logic [2:0]           hsize;
    logic [31:0]          hwdata, hrdata, rd_q;
    logic [3:0]           irq_pending, irq_enabled, irq_high_pri;
    logic                 cycle_tick, ring_active, crystal_amp_en;
    scc_pkg::scc_level_t  level;
    scc_pkg::scc_serial_t serial;
    int                   errors, samples_checked;
    int                   m_div, m_swb, m_src, m_off, m_crystal_ready_flag, m_ring;

    scc_clock_ctrl #(.N_IRQ(4), .ADDR_W(12), .WARMUP_CLOCKS(WARM)) i_scc_clock_ctrl (
        .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_pending(irq_pending),
        .irq_enabled(irq_enabled), .irq_high_pri(irq_high_pri), .level(level),
        .serial(serial), .cycle_tick(cycle_tick), .div_code(div_code),
        .ring_active(ring_active), .crystal_amp_en(crystal_amp_en));

    // Clock at 100 MHz
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Bus answer copied mid-cycle, so the rising edge sees settled values
    always @(negedge ref_clk) begin
        rdy_q <= hreadyout;
        rd_q  <= hrdata;
        rsp_q <= hresp;
    end

    task automatic end_of_test();
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t output %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_per(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            errors++;
            $display("CHECK FAILED t=%0t tick period %0d expected %0d", $time, got, exp);
        end
    endtask

    // One single AHB-Lite transfer; holds each phase until hready is seen high
    task automatic bus_op(input logic wr, input logic [11:0] a, input logic [7:0] d,
                          output logic [31:0] rd);
        logic [31:0] r;
        int          n;
        r = $urandom();
        n = 0;
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= a;
        do begin @(posedge ref_clk); n++; end while (rdy_q !== 1'b1 && n < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {r[31:8], d};
        do begin @(posedge ref_clk); n++; end while (rdy_q !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            $display("CHECK FAILED t=%0t bus transfer hung", $time);
        end
        samples_checked++;
        if (rsp_q !== 1'b0) begin
            errors++;
            $display("CHECK FAILED t=%0t error response", $time);
        end
        rd = rd_q;
    endtask

    // Expected register contents from the bench model
    function automatic logic [31:0] exp_rd(input logic [11:0] a);
        case (a)
            A_EXT_IRQ_FLAG_CLOCK_SOURCE:  return 32'(m_src * 8 + m_ring * 4);
            A_PMR:   return 32'(m_div * 64 + m_swb * 32 + m_off * 8);
            A_STS:   return {24'h0, level, m_crystal_ready_flag[0], 2'h0, serial.tx_active, serial.rx_active};
            default: return 32'h0;
        endcase
    endfunction

    // Write plus model update with the field refusals
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] unused;
        logic        lock;
        bus_op(1'b1, a, d, unused);
        lock = serial.rx_active | serial.tx_active;
        lock = lock | (m_swb[0] & (serial.start_bit | serial.rx_active));
        if (a == A_PMR) begin
            if (d[7:6] != 2'h0 && !lock && (d[7:6] == 2'h1 || m_div == 1)) m_div = d[7:6];
            m_swb = d[5];
            if (!d[3] || m_src == 0) m_off = d[3];
            if (d[3] && m_src == 0) m_crystal_ready_flag = 0;
        end
        if (a == A_EXT_IRQ_FLAG_CLOCK_SOURCE && (!d[3] || m_crystal_ready_flag == 1)) m_src = d[3];
    endtask

    task automatic rdc(input logic [11:0] a);
        logic [31:0] got;
        bus_op(1'b0, a, 8'h00, got);
        chk_rd(got, exp_rd(a));
    endtask

    // Waits k ticks, returns the last spacing; ends at a falling edge
    task automatic ticks(input int k, output int per);
        int n;
        n = 0;
        repeat (k) begin
            n = 0;
            do begin @(negedge ref_clk); n++; end while (cycle_tick !== 1'b1 && n < 3000);
            if (n >= 3000) begin
                errors++;
                $display("CHECK FAILED t=%0t no cycle tick", $time);
            end
        end
        per = n;
        m_ring = (m_src == 0);
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // Hang guard
    initial begin
        #600000;
        errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        int p;
        int src;
        {hsel, haddr, htrans, hwrite, hwdata, irq_pending, irq_enabled, irq_high_pri} = '0;
        hsize = 3'h2;
        level = '0;
        serial = '0;
        reset = 1'b1;
        {errors, samples_checked, m_swb, m_off, m_ring} = '0;
        {m_div, m_src, m_crystal_ready_flag} = {32'd1, 32'd1, 32'd1};
        void'($urandom(3458));
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rdc(A_EXT_IRQ_FLAG_CLOCK_SOURCE);
        rdc(A_PMR);
        rdc(A_STS);
        wr(A_NONE, 8'hFF);
        rdc(A_NONE);
        ticks(3, p);
        chk_per(p, 4);
        chk_pin({1'b0, crystal_amp_en}, 2'h1);
        // Both slow rates, slow-to-slow and reserved writes refused
        for (int i = 0; i < 2; i++) begin
            logic [1:0] c;
            c = 2'(i + 2);
            wr(A_PMR, {c, 6'h00});
            ticks(3, p);
            chk_per(p, i ? 1024 : 64);
            chk_pin(div_code, c);
            wr(A_PMR, {c ^ 2'h1, 6'h00});
            wr(A_PMR, 8'h00);
            rdc(A_PMR);
            wr(A_PMR, 8'h40);
            ticks(3, p);
            chk_per(p, 4);
        end
        // Serial activity locks the divider
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            serial.rx_active <= (k == 0);
            serial.tx_active <= (k == 1);
            wr(A_PMR, 8'h80);
            rdc(A_PMR);
            rdc(A_STS);
            @(posedge ref_clk);
            serial <= '0;
        end
        // Interrupt switchback, blocked by levels in service first
        src = $urandom_range(3, 0);
        rdc(A_STS);
        wr(A_PMR, 8'hA0);
        ticks(2, p);
        @(posedge ref_clk);
        irq_enabled  <= 4'($urandom()) | 4'(1 << src);
        irq_high_pri <= 4'($urandom()) & ~4'(1 << src);
        irq_pending  <= 4'(1 << src);
        level        <= 3'h2;
        look(8);
        chk_pin(div_code, 2'h2);
        rdc(A_STS);
        @(posedge ref_clk);
        level <= 3'h1;
        look(8);
        chk_pin(div_code, 2'h2);
        @(posedge ref_clk);
        level <= '0;
        look(3);
        chk_pin(div_code, 2'h1);
        m_div = 1;
        rdc(A_PMR);
        @(posedge ref_clk);
        irq_pending <= '0;
        // Start bit switchback, then divider writes locked
        wr(A_PMR, 8'hA0);
        ticks(2, p);
        @(posedge ref_clk);
        serial.rx_enable <= 1'b1;
        serial.start_bit <= 1'b1;
        look(3);
        chk_pin(div_code, 2'h1);
        m_div = 1;
        wr(A_PMR, 8'hA0);
        rdc(A_PMR);
        @(posedge ref_clk);
        serial <= '0;
        // Crystal off refused on crystal, then ring and warm-up
        wr(A_PMR, 8'h08);
        look(1);
        chk_pin({1'b0, crystal_amp_en}, 2'h1);
        wr(A_EXT_IRQ_FLAG_CLOCK_SOURCE, 8'h00);
        ticks(2, p);
        chk_per(p, 4);
        chk_pin({1'b0, ring_active}, 2'h1);
        rdc(A_EXT_IRQ_FLAG_CLOCK_SOURCE);
        wr(A_PMR, 8'h08);
        look(2);
        chk_pin({1'b0, crystal_amp_en}, 2'h0);
        rdc(A_STS);
        wr(A_EXT_IRQ_FLAG_CLOCK_SOURCE, 8'h08);
        rdc(A_EXT_IRQ_FLAG_CLOCK_SOURCE);
        wr(A_PMR, 8'hA8);
        ticks(2, p);
        @(posedge ref_clk);
        irq_pending <= 4'(1 << src);
        look(3);
        chk_pin(div_code, 2'h1);
        chk_pin({1'b0, ring_active}, 2'h1);
        m_div = 1;
        @(posedge ref_clk);
        irq_pending <= '0;
        wr(A_PMR, 8'h40);
        rdc(A_STS);
        look(WARM + 8);
        m_crystal_ready_flag = 1;
        rdc(A_STS);
        wr(A_EXT_IRQ_FLAG_CLOCK_SOURCE, 8'h08);
        ticks(2, p);
        chk_pin({1'b0, ring_active}, 2'h0);
        rdc(A_EXT_IRQ_FLAG_CLOCK_SOURCE);
        end_of_test();
    end
endmodule

// >>> rtl/scc_clock_ctrl.sv
// Slow clock source control: divider, crystal/ring select, warm-up, switchback, AHB-Lite slave
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
`include "scc_consts.svh"

module scc_clock_ctrl #(
    parameter int N_IRQ         = 4,
    parameter int ADDR_W        = 12,
    parameter int WARMUP_CLOCKS = `SCC_WARMUP_CLOCKS
) (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [ADDR_W-1:0]   haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // External interrupts and priority state
    input  wire logic [N_IRQ-1:0]    irq_pending,
    input  wire logic [N_IRQ-1:0]    irq_enabled,
    input  wire logic [N_IRQ-1:0]    irq_high_pri,
    input  wire scc_pkg::scc_level_t level,
    // Serial port 0 activity
    input  wire scc_pkg::scc_serial_t serial,
    // Clock outputs
    output logic                     cycle_tick,
    output logic [1:0]               div_code,
    output logic                     ring_active,
    output logic                     crystal_amp_en
);

    // Whole block state and its next value
    scc_pkg::scc_state_t s;
    scc_pkg::scc_state_t next_s;

    // Helpers from state and live inputs
    logic [N_IRQ-1:0] irq_ok;
    logic             irq_take;
    logic             sb;
    logic             protect;
    logic [9:0]       div_len_m1;
    logic [1:0]       wr_div;
    logic             addr_ok;
    logic [7:0]       rd8;

    // Per-source check that the interrupt could really be taken now
    // Power-fail or high level masks all; a low level masks low sources
    genvar gi;
    generate
        for (gi = 0; gi < N_IRQ; gi = gi + 1) begin : g_irq
            assign irq_ok[gi] = irq_pending[gi] & irq_enabled[gi]
                              & ~level.powerfail_level_busy
                              & ~level.high_level_busy
                              & (irq_high_pri[gi] | ~level.low_level_busy);
        end
    endgenerate

    // Switchback request and divider write lock
    // Lock reads live serial inputs, so with switchback enabled a start bit blocks that same write
    assign irq_take = |irq_ok;
    assign sb       = s.auto_return_enable & (irq_take | (serial.rx_enable & serial.start_bit));
    assign protect  = serial.rx_active | serial.tx_active
                    | (s.auto_return_enable & (serial.start_bit | serial.rx_active));
    assign wr_div   = hwdata[`SCC_PMR_DIV_HI:`SCC_PMR_DIV_LO];
    assign addr_ok  = (haddr[1:0] == 2'h0);

    // Terminal count for the active divider
    // Reserved code cannot be active; default keeps the fast rate
    always_comb begin
        case (s.div_act)
            `SCC_DIV_64:   div_len_m1 = `SCC_LEN_64;
            `SCC_DIV_1024: div_len_m1 = `SCC_LEN_1024;
            default:       div_len_m1 = `SCC_LEN_4;
        endcase
    end

    // Read data assembled from state and live status inputs
    // Level and serial bits are not stored, so a read shows them now
    always_comb begin
        rd8 = 8'h00;
        case (s.sel)
            scc_pkg::SCC_REG_EXT_IRQ_FLAG_CLOCK_SOURCE: begin
                rd8[`SCC_EXT_IRQ_FLAG_CLOCK_SOURCE_SRC_BIT]  = s.src_sel;
                rd8[`SCC_EXT_IRQ_FLAG_CLOCK_SOURCE_RING_BIT] = ~s.src_act;
            end
            scc_pkg::SCC_REG_PMR: begin
                rd8[`SCC_PMR_DIV_HI:`SCC_PMR_DIV_LO] = s.div_sel;
                rd8[`SCC_PMR_SWB_BIT]                = s.auto_return_enable;
                rd8[`SCC_PMR_AMPOFF_BIT]             = s.amp_off;
            end
            scc_pkg::SCC_REG_STATUS: begin
                rd8[`SCC_STS_PF_BIT]   = level.powerfail_level_busy;
                rd8[`SCC_STS_HI_BIT]   = level.high_level_busy;
                rd8[`SCC_STS_LO_BIT]   = level.low_level_busy;
                rd8[`SCC_STS_CRYSTAL_READY_FLAG_BIT] = s.xt_ready;
                rd8[`SCC_STS_TX_BIT]   = serial.tx_active;
                rd8[`SCC_STS_RX_BIT]   = serial.rx_active;
            end
            default: rd8 = 8'h00;
        endcase
    end

    // Next-state logic
    // Order matters: switchback after the writes, bus decode last
    always_comb begin
        next_s         = s;
        next_s.tick    = 1'b0;
        next_s.wr_pend = 1'b0;

        // Instruction cycle divider, same for crystal or ring source
        // New divider and source land at the cycle boundary; switchback below forces the fast rate at once
        if (s.div_cnt >= div_len_m1) begin
            next_s.div_cnt = 10'h000;
            next_s.tick    = 1'b1;
            next_s.div_act = s.div_sel;
            if (!s.src_sel) begin
                next_s.src_act = 1'b0;
            end else if (s.xst == scc_pkg::SCC_XT_READY) begin
                next_s.src_act = 1'b1;
            end
        end else begin
            next_s.div_cnt = s.div_cnt + 10'h001;
        end

        // Register writes in the data phase
        // Refused fields keep their value; the bus still answers OKAY
        if (s.wr_pend && s.sel == scc_pkg::SCC_REG_PMR) begin
            if (!protect && wr_div != `SCC_DIV_RSVD
                && (wr_div == `SCC_DIV_4
                    || (s.div_act == `SCC_DIV_4 && s.div_sel == `SCC_DIV_4))) begin
                next_s.div_sel = wr_div;
            end
            next_s.auto_return_enable = hwdata[`SCC_PMR_SWB_BIT];
            if (!hwdata[`SCC_PMR_AMPOFF_BIT]) begin
                next_s.amp_off = 1'b0;
            end else if (!s.src_sel) begin
                next_s.amp_off = 1'b1;
            end
        end
        // Ready lags crystal-off by one edge, so check both
        if (s.wr_pend && s.sel == scc_pkg::SCC_REG_EXT_IRQ_FLAG_CLOCK_SOURCE) begin
            if (!hwdata[`SCC_EXT_IRQ_FLAG_CLOCK_SOURCE_SRC_BIT]) begin
                next_s.src_sel = 1'b0;
            end else if (s.xt_ready && !s.amp_off) begin
                next_s.src_sel = 1'b1;
            end
        end

        // Switchback wins over a divider write; source is left alone
        // Counter cleared so a full fast cycle starts at once
        if (sb) begin
            next_s.div_sel = `SCC_DIV_4;
            next_s.div_act = `SCC_DIV_4;
            next_s.div_cnt = 10'h000;
        end

        // Crystal amplifier and warm-up timer
        // Ready drops the edge after crystal-off lands
        case (s.xst)
            scc_pkg::SCC_XT_READY: begin
                if (s.amp_off) begin
                    next_s.xst      = scc_pkg::SCC_XT_OFF;
                    next_s.xt_ready = 1'b0;
                end
            end
            scc_pkg::SCC_XT_OFF: begin
                if (!s.amp_off) begin
                    next_s.xst      = scc_pkg::SCC_XT_WARM;
                    next_s.warm_cnt = '0;
                end
            end
            scc_pkg::SCC_XT_WARM: begin
                if (s.amp_off) begin
                    next_s.xst = scc_pkg::SCC_XT_OFF;
                end else if (s.warm_cnt == 17'(WARMUP_CLOCKS - 1)) begin
                    next_s.xst      = scc_pkg::SCC_XT_READY;
                    next_s.xt_ready = 1'b1;
                end else begin
                    next_s.warm_cnt = s.warm_cnt + 17'h00001;
                end
            end
            default: begin
                next_s.xst = scc_pkg::SCC_XT_OFF;
            end
        endcase

        // AHB-Lite: read data phase gets one wait state
        // Writes need no wait; reads take one to register the data
        if (s.rd_pend) begin
            next_s.rd_pend = 1'b0;
            next_s.hready  = 1'b1;
            next_s.hrdata  = {24'h000000, rd8};
        end
        if (hsel && htrans[1] && hready) begin
            next_s.wr_pend = hwrite;
            next_s.rd_pend = ~hwrite;
            next_s.hready  = hwrite;
            if (!addr_ok) begin
                next_s.sel = scc_pkg::SCC_REG_NONE;
            end else if (haddr[ADDR_W-1:2] == 10'(`SCC_IDX_EXT_IRQ_FLAG_CLOCK_SOURCE)) begin
                next_s.sel = scc_pkg::SCC_REG_EXT_IRQ_FLAG_CLOCK_SOURCE;
            end else if (haddr[ADDR_W-1:2] == 10'(`SCC_IDX_PMR)) begin
                next_s.sel = scc_pkg::SCC_REG_PMR;
            end else if (haddr[ADDR_W-1:2] == 10'(`SCC_IDX_STATUS)) begin
                next_s.sel = scc_pkg::SCC_REG_STATUS;
            end else begin
                next_s.sel = scc_pkg::SCC_REG_NONE;
            end
        end
        next_s.hresp = 1'b0;
    end

    // State register
    // Synchronous reset; fields not listed come up as zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s          <= '0;
            s.div_sel  <= `SCC_RST_DIV;
            s.div_act  <= `SCC_RST_DIV;
            s.src_sel  <= `SCC_RST_SRC;
            s.src_act  <= `SCC_RST_SRC;
            s.xt_ready <= `SCC_RST_CRYSTAL_READY_FLAG;
            s.amp_off  <= 1'b0;
            s.xst      <= scc_pkg::SCC_XT_READY;
            s.hready   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    // Every output is a state bit or its inverse, so none can glitch
    assign hreadyout      = s.hready;
    assign hresp          = s.hresp;
    assign hrdata         = s.hrdata;
    assign cycle_tick     = s.tick;
    assign div_code       = s.div_act;
    assign ring_active    = ~s.src_act;
    assign crystal_amp_en = ~s.amp_off;

    // Checks on the state, all in the ref_clk domain
    // Counter never passes the active terminal count
    div_range_a : assert property (@(posedge ref_clk) disable iff (reset)
        (s.div_cnt <= div_len_m1) && (s.div_act != `SCC_DIV_RSVD))
        else $error("divider counter or code out of range");

    // Active divider changes only at a cycle boundary or on switchback
    div_delay_a : assert property (@(posedge ref_clk) disable iff (reset)
        (s.div_act != $past(s.div_act)) |-> ($past(s.div_cnt >= div_len_m1) || $past(sb)))
        else $error("divider changed mid cycle");

    // Slow code accepted only from the fast rate
    slow_entry_a : assert property (@(posedge ref_clk) disable iff (reset)
        (s.div_sel != $past(s.div_sel) && s.div_sel[1])
        |-> ($past(s.div_act) == `SCC_DIV_4 && $past(s.div_sel) == `SCC_DIV_4))
        else $error("slow rate entered from slow rate");

    // Switchback yields fast rate next cycle, with the counter cleared
    switch_back_a : assert property (@(posedge ref_clk) disable iff (reset)
        sb |=> (s.div_act == `SCC_DIV_4 && s.div_sel == `SCC_DIV_4 && s.div_cnt == 10'h000))
        else $error("switchback did not restore fast rate");

    // A busy high level blocks every interrupt switchback
    irq_block_a : assert property (@(posedge ref_clk) disable iff (reset)
        (level.high_level_busy || level.powerfail_level_busy) |-> !irq_take)
        else $error("blocked interrupt requested switchback");

    // Locked divider keeps its value on write
    div_lock_a : assert property (@(posedge ref_clk) disable iff (reset)
        (s.wr_pend && protect && !sb) |=> (s.div_sel == $past(s.div_sel)))
        else $error("divider written while locked");

    // Crystal off only set while ring selected
    amp_off_a : assert property (@(posedge ref_clk) disable iff (reset)
        $rose(s.amp_off) |-> !$past(s.src_sel))
        else $error("crystal off set with crystal selected");

    // Ready flag rises only at the end of the full warm-up count
    warm_up_a : assert property (@(posedge ref_clk) disable iff (reset)
        $rose(s.xt_ready) |-> ($past(s.warm_cnt) == 17'(WARMUP_CLOCKS - 1)
                               && $past(s.xst) == scc_pkg::SCC_XT_WARM))
        else $error("crystal ready without warm-up");

    // Crystal cannot be selected before it is ready
    src_guard_a : assert property (@(posedge ref_clk) disable iff (reset)
        $rose(s.src_sel) |-> $past(s.xt_ready))
        else $error("crystal selected before ready");

    // Active source changes only at a cycle boundary
    src_delay_a : assert property (@(posedge ref_clk) disable iff (reset)
        (s.src_act != $past(s.src_act)) |-> $past(s.div_cnt >= div_len_m1))
        else $error("source changed mid cycle");

    // Tick is a one-clock pulse
    tick_pulse_a : assert property (@(posedge ref_clk) disable iff (reset)
        s.tick |=> !s.tick)
        else $error("cycle tick longer than one clock");

    // Tick only at the terminal count of the active divider
    tick_count_a : assert property (@(posedge ref_clk) disable iff (reset)
        s.tick |-> $past(s.div_cnt == div_len_m1))
        else $error("cycle tick away from terminal count");

    // At a cycle boundary without switchback the selected divider goes live
    div_follow_a : assert property (@(posedge ref_clk) disable iff (reset)
        ($past(s.div_cnt >= div_len_m1) && !$past(sb))
        |-> (s.div_act == $past(s.div_sel)))
        else $error("selected divider not applied at cycle boundary");

    // Reserved divider code never stored
    div_rsvd_a : assert property (@(posedge ref_clk) disable iff (reset)
        s.div_sel != `SCC_DIV_RSVD)
        else $error("reserved divider code stored");

    // A busy low level leaves only high-priority sources able to switch back
    lo_block_a : assert property (@(posedge ref_clk) disable iff (reset)
        (level.low_level_busy && irq_take)
        |-> |(irq_pending & irq_enabled & irq_high_pri))
        else $error("low level in service did not block low source");

    // Crystal-off and crystal select never stand together
    amp_src_a : assert property (@(posedge ref_clk) disable iff (reset)
        s.amp_off |-> !s.src_sel)
        else $error("crystal selected with amplifier off");

    // Ready drops once the amplifier is off
    ready_drop_a : assert property (@(posedge ref_clk) disable iff (reset)
        s.amp_off |=> !s.xt_ready)
        else $error("crystal ready with amplifier off");

    // Ready is only shown in the settled state
    ready_hold_a : assert property (@(posedge ref_clk) disable iff (reset)
        (s.xst != scc_pkg::SCC_XT_READY) |-> !s.xt_ready)
        else $error("crystal ready before warm-up ends");

    // Ring selection goes live at the next cycle boundary
    ring_follow_a : assert property (@(posedge ref_clk) disable iff (reset)
        ($past(s.div_cnt >= div_len_m1) && !$past(s.src_sel))
        |-> !s.src_act)
        else $error("ring selection not applied at cycle boundary");

    // Switchback leaves the source selection alone
    src_keep_a : assert property (@(posedge ref_clk) disable iff (reset)
        (sb && !(s.wr_pend && s.sel == scc_pkg::SCC_REG_EXT_IRQ_FLAG_CLOCK_SOURCE))
        |=> (s.src_sel == $past(s.src_sel)))
        else $error("switchback changed the clock source");

endmodule

// >>> rtl/scc_consts.svh
// Register offsets, field positions, reset values and timing counts of the clock control
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// Register indices; byte address is four times the index
`define SCC_IDX_EXT_IRQ_FLAG_CLOCK_SOURCE        10'h091
`define SCC_IDX_PMR         10'h0C4
`define SCC_IDX_STATUS      10'h0C5

// Clock source register fields
`define SCC_EXT_IRQ_FLAG_CLOCK_SOURCE_SRC_BIT    3
`define SCC_EXT_IRQ_FLAG_CLOCK_SOURCE_RING_BIT   2

// Power management register fields
`define SCC_PMR_DIV_HI      7
`define SCC_PMR_DIV_LO      6
`define SCC_PMR_SWB_BIT     5
`define SCC_PMR_AMPOFF_BIT  3

// Status register fields
`define SCC_STS_PF_BIT      7
`define SCC_STS_HI_BIT      6
`define SCC_STS_LO_BIT      5
`define SCC_STS_CRYSTAL_READY_FLAG_BIT    4
`define SCC_STS_TX_BIT      1
`define SCC_STS_RX_BIT      0

// Divider codes and terminal counts
`define SCC_DIV_RSVD        2'h0
`define SCC_DIV_4           2'h1
`define SCC_DIV_64          2'h2
`define SCC_DIV_1024        2'h3
`define SCC_LEN_4           10'h003
`define SCC_LEN_64          10'h03F
`define SCC_LEN_1024        10'h3FF

// Reset values
`define SCC_RST_DIV         2'h1
`define SCC_RST_SRC         1'h1
`define SCC_RST_CRYSTAL_READY_FLAG        1'h1

// Crystal warm-up, in crystal clocks
`define SCC_WARMUP_CLOCKS   65536
`define SCC_WARM_W          17

`endif

// >>> rtl/scc_pkg.sv
// Types shared by the slow clock source control
package scc_pkg;

    // Crystal amplifier state, Gray coded along ready -> off -> warm
    typedef enum logic [1:0] {
        SCC_XT_READY = 2'h0,
        SCC_XT_OFF   = 2'h1,
        SCC_XT_WARM  = 2'h3
    } scc_xtal_t;

    // Register selected in the data phase
    typedef enum logic [1:0] {
        SCC_REG_NONE   = 2'h0,
        SCC_REG_EXT_IRQ_FLAG_CLOCK_SOURCE   = 2'h1,
        SCC_REG_PMR    = 2'h2,
        SCC_REG_STATUS = 2'h3
    } scc_reg_t;

    // Serial port 0 activity as seen by the clock control
    typedef struct packed {
        logic rx_enable;
        logic start_bit;
        logic rx_active;
        logic tx_active;
    } scc_serial_t;

    // Interrupt priority levels now in service
    typedef struct packed {
        logic powerfail_level_busy;
        logic high_level_busy;
        logic low_level_busy;
    } scc_level_t;

    // Whole state of the block
    typedef struct packed {
        logic [1:0]  div_sel;
        logic [1:0]  div_act;
        logic        auto_return_enable;
        logic        src_sel;
        logic        src_act;
        logic        amp_off;
        logic        xt_ready;
        scc_xtal_t   xst;
        logic [16:0] warm_cnt;
        logic [9:0]  div_cnt;
        logic        tick;
        logic        wr_pend;
        logic        rd_pend;
        scc_reg_t    sel;
        logic        hready;
        logic        hresp;
        logic [31:0] hrdata;
    } scc_state_t;

endpackage
